// ===== logic/tpis_i2c_port.sv
`timescale 1ns/1ps

module tpis_i2c_port
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // address strap and status source
  input  wire logic [1:0] address_select_input,
  input  wire logic [7:0] status_byte,
  // settings
  output logic      [7:0] divider_hi,
  output logic      [7:0] divider_lo,
  output logic      [7:0] control_byte,
  output logic      [7:0] band_byte,
  output logic      [7:0] aux_byte,
  output logic      [4:0] setting_update
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    tpis_pkg::tpis_state_e state;
    tpis_pkg::tpis_next_e  route;
    logic [7:0]            shreg;
    logic [3:0]            cnt;
    logic                  nack;
    logic                  scl_d;
    logic                  sda_d;
    logic                  sda_oe;
    logic                  sda_out;
    logic [7:0]            div_hi;
    logic [7:0]            div_lo;
    logic [7:0]            ctrl;
    logic [7:0]            band;
    logic [7:0]            aux;
    logic [4:0]            upd;
  } tpis_port_s;

  tpis_port_s r;
  tpis_port_s next_r;
  logic [3:0] synced;
  logic       scl_s;
  logic       sda_s;
  logic [1:0] as_s;
  logic       start;
  logic       stop;
  logic       rise;
  logic       fall;
  logic       wr_done;

  // compares the received address with the strapped one
  function automatic logic addr_match(input logic [6:0] a,
                                      input logic [1:0] sel);
    addr_match = (a == {tpis_pkg::ADDR_BASE, sel});
  endfunction

  // ----------------------------------------------------------------
  // pin retiming
  // ----------------------------------------------------------------
  tpis_sync u_sync
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .raw      ({address_select_input, sda_in, scl_in}),
    .synced   (synced)
  );

  // bus conditions from retimed levels
  assign scl_s   = synced[0];
  assign sda_s   = synced[1];
  assign as_s    = synced[3:2];
  assign start   = r.scl_d && scl_s && r.sda_d && !sda_s;
  assign stop    = r.scl_d && scl_s && !r.sda_d && sda_s;
  assign rise    = !r.scl_d && scl_s;
  assign fall    = r.scl_d && !scl_s;
  assign wr_done = (r.state == tpis_pkg::ST_WR_DATA) && fall &&
                   (r.cnt == tpis_pkg::BITS_PER_BYTE);

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  // sda is only changed after a detected scl fall, which keeps data
  // stable across the high phase as the bus requires
  always_comb
  begin
    next_r         = r;
    next_r.upd     = '0;
    next_r.scl_d   = scl_s;
    next_r.sda_d   = sda_s;
    next_r.sda_out = 1'b0;
    if (start)
    begin
      next_r.state  = tpis_pkg::ST_ADDR;
      next_r.cnt    = 4'h0;
      next_r.sda_oe = 1'b0;
    end
    else if (stop)
    begin
      next_r.state  = tpis_pkg::ST_IDLE;
      next_r.sda_oe = 1'b0;
    end
    else
    begin
      unique case (r.state)
        tpis_pkg::ST_IDLE:
        begin
          next_r.sda_oe = 1'b0;
        end
        tpis_pkg::ST_ADDR:
        begin
          if (rise)
          begin
            next_r.shreg = {r.shreg[6:0], sda_s};
            next_r.cnt   = r.cnt + 4'h1;
          end
          else if (fall && r.cnt == tpis_pkg::BITS_PER_BYTE)
          begin
            if (addr_match(r.shreg[7:1], as_s))
            begin
              next_r.state  = tpis_pkg::ST_ADDR_ACK;
              next_r.sda_oe = 1'b1;
              next_r.route  = tpis_pkg::NX_ANY;
            end
            else
            begin
              next_r.state = tpis_pkg::ST_IDLE;
            end
          end
        end
        tpis_pkg::ST_ADDR_ACK:
        begin
          if (fall && r.shreg[0])
          begin
            next_r.state  = tpis_pkg::ST_RD_DATA;
            next_r.shreg  = status_byte;
            next_r.sda_oe = !status_byte[7];
            next_r.cnt    = 4'h1;
          end
          else if (fall)
          begin
            next_r.state  = tpis_pkg::ST_WR_DATA;
            next_r.sda_oe = 1'b0;
            next_r.cnt    = 4'h0;
          end
        end
        tpis_pkg::ST_WR_DATA:
        begin
          if (rise)
          begin
            next_r.shreg = {r.shreg[6:0], sda_s};
            next_r.cnt   = r.cnt + 4'h1;
          end
          else if (wr_done)
          begin
            // commit at the ack so a byte cut short never lands
            next_r.state  = tpis_pkg::ST_WR_ACK;
            next_r.sda_oe = 1'b1;
            unique case (r.route)
              tpis_pkg::NX_ANY:
              begin
                if (r.shreg[tpis_pkg::CTRL_FLAG_BIT])
                begin
                  next_r.ctrl = r.shreg;
                  next_r.upd[tpis_pkg::UPD_CTRL] = 1'b1;
                  next_r.route = r.shreg[tpis_pkg::AUX_SEL_BIT] ?
                                 tpis_pkg::NX_AUX : tpis_pkg::NX_BAND;
                end
                else
                begin
                  next_r.div_hi = r.shreg;
                  next_r.upd[tpis_pkg::UPD_DIV_HI] = 1'b1;
                  next_r.route = tpis_pkg::NX_DIV2;
                end
              end
              tpis_pkg::NX_DIV2:
              begin
                next_r.div_lo = r.shreg;
                next_r.upd[tpis_pkg::UPD_DIV_LO] = 1'b1;
                next_r.route = tpis_pkg::NX_ANY;
              end
              tpis_pkg::NX_BAND:
              begin
                next_r.band = r.shreg;
                next_r.upd[tpis_pkg::UPD_BAND] = 1'b1;
                next_r.route = tpis_pkg::NX_ANY;
              end
              tpis_pkg::NX_AUX:
              begin
                next_r.aux = r.shreg;
                next_r.upd[tpis_pkg::UPD_AUX] = 1'b1;
                next_r.route = tpis_pkg::NX_ANY;
              end
            endcase
          end
        end
        tpis_pkg::ST_WR_ACK:
        begin
          if (fall)
          begin
            next_r.state  = tpis_pkg::ST_WR_DATA;
            next_r.sda_oe = 1'b0;
            next_r.cnt    = 4'h0;
          end
        end
        tpis_pkg::ST_RD_DATA:
        begin
          if (fall && r.cnt == tpis_pkg::BITS_PER_BYTE)
          begin
            next_r.state  = tpis_pkg::ST_RD_ACK;
            next_r.sda_oe = 1'b0;
          end
          else if (fall)
          begin
            next_r.shreg  = {r.shreg[6:0], 1'b0};
            next_r.sda_oe = !r.shreg[6];
            next_r.cnt    = r.cnt + 4'h1;
          end
        end
        tpis_pkg::ST_RD_ACK:
        begin
          if (rise)
          begin
            next_r.nack = sda_s;
          end
          else if (fall && !r.nack)
          begin
            next_r.state  = tpis_pkg::ST_RD_DATA;
            next_r.shreg  = status_byte;
            next_r.sda_oe = !status_byte[7];
            next_r.cnt    = 4'h1;
          end
          else if (fall)
          begin
            next_r.state = tpis_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r <= '{state: tpis_pkg::ST_IDLE, route: tpis_pkg::NX_ANY,
             shreg: 8'h00, cnt: 4'h0, nack: 1'b1, scl_d: 1'b1,
             sda_d: 1'b1, sda_oe: 1'b0, sda_out: 1'b0,
             div_hi: tpis_pkg::SETTING_RESET,
             div_lo: tpis_pkg::SETTING_RESET,
             ctrl: tpis_pkg::SETTING_RESET,
             band: tpis_pkg::SETTING_RESET,
             aux: tpis_pkg::SETTING_RESET, upd: 5'h00};
    end
    else
    begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  assign sda_out        = r.sda_out;
  assign sda_oe         = r.sda_oe;
  assign divider_hi     = r.div_hi;
  assign divider_lo     = r.div_lo;
  assign control_byte   = r.ctrl;
  assign band_byte      = r.band;
  assign aux_byte       = r.aux;
  assign setting_update = r.upd;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_ack_drive: assert property (@(posedge core_clk) disable iff (!resetn)
    (r.state == tpis_pkg::ST_ADDR_ACK || r.state == tpis_pkg::ST_WR_ACK)
    |-> r.sda_oe) else $error("ack not driven");
  chk_addr_ignore: assert property (@(posedge core_clk) disable iff (!resetn)
    (r.state == tpis_pkg::ST_ADDR && fall && !start && !stop &&
     r.cnt == tpis_pkg::BITS_PER_BYTE && !addr_match(r.shreg[7:1], as_s))
    |=> r.state == tpis_pkg::ST_IDLE && !r.sda_oe)
    else $error("foreign address acknowledged");
  chk_addr_select: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(r.state == tpis_pkg::ST_ADDR_ACK)
    |-> r.shreg[7:1] == {tpis_pkg::ADDR_BASE, $past(as_s)})
    else $error("address select ignored");
  chk_div_route: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_done && r.route == tpis_pkg::NX_ANY && !r.shreg[7])
    |=> r.div_hi == $past(r.shreg) && r.route == tpis_pkg::NX_DIV2)
    else $error("divider 1 not stored");
  chk_ctrl_route: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_done && r.route == tpis_pkg::NX_ANY && r.shreg[7])
    |=> r.ctrl == $past(r.shreg) &&
        (r.route == tpis_pkg::NX_AUX) == $past(r.shreg[4]))
    else $error("control byte routing wrong");
  chk_band_store: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_done && r.route == tpis_pkg::NX_BAND)
    |=> r.band == $past(r.shreg) && r.upd[tpis_pkg::UPD_BAND])
    else $error("band byte not stored");
  chk_aux_store: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_done && r.route == tpis_pkg::NX_AUX)
    |=> r.aux == $past(r.shreg) ##1 r.upd == 5'h00)
    else $error("aux byte not stored");
  chk_hold_settings: assert property (@(posedge core_clk) disable iff (!resetn)
    !wr_done |=> $stable(r.div_hi) && $stable(r.ctrl) && $stable(r.aux))
    else $error("setting changed without a byte");
  chk_read_drive: assert property (@(posedge core_clk) disable iff (!resetn)
    r.state == tpis_pkg::ST_RD_DATA |-> r.sda_oe == !r.shreg[7])
    else $error("status bit driven wrong");
  chk_nack_release: assert property (@(posedge core_clk) disable iff (!resetn)
    (r.state == tpis_pkg::ST_RD_ACK && fall && r.nack && !start && !stop)
    |=> r.state == tpis_pkg::ST_IDLE ##1 !r.sda_oe)
    else $error("bus not released after nack");
  chk_second_status: assert property (@(posedge core_clk) disable iff (!resetn)
    (r.state == tpis_pkg::ST_RD_ACK && fall && !r.nack && !start && !stop)
    |=> r.state == tpis_pkg::ST_RD_DATA && r.shreg == $past(status_byte))
    else $error("second status byte missing");

endmodule // tpis_i2c_port

// ===== logic/tpis_pkg.sv
package tpis_pkg;

  // ----------------------------------------------------------------
  // bus addressing
  // ----------------------------------------------------------------
  // upper five bits of the 7-bit target address; the low two come from
  // the address select input
  localparam logic [4:0] ADDR_BASE     = 5'h18;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // byte field positions
  // ----------------------------------------------------------------
  localparam int CTRL_FLAG_BIT = 7;  // set: control byte, clear: divider 1
  localparam int AUX_SEL_BIT   = 4;  // in control byte: aux byte follows

  // ----------------------------------------------------------------
  // reset values and update strobe positions
  // ----------------------------------------------------------------
  localparam logic [7:0] SETTING_RESET = 8'h00;
  localparam int UPD_DIV_HI = 0;
  localparam int UPD_DIV_LO = 1;
  localparam int UPD_CTRL   = 2;
  localparam int UPD_BAND   = 3;
  localparam int UPD_AUX    = 4;
  localparam int UPD_WIDTH  = 5;

  // ----------------------------------------------------------------
  // state machine and byte routing
  // ----------------------------------------------------------------
  typedef enum logic [6:0]
  {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WR_DATA  = 7'h08,
    ST_WR_ACK   = 7'h10,
    ST_RD_DATA  = 7'h20,
    ST_RD_ACK   = 7'h40
  } tpis_state_e;

  typedef enum logic [3:0]
  {
    NX_ANY  = 4'h1,
    NX_DIV2 = 4'h2,
    NX_BAND = 4'h4,
    NX_AUX  = 4'h8
  } tpis_next_e;

endpackage

// ===== logic/tpis_sync.sv
`timescale 1ns/1ps

module tpis_sync
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // raw pin levels
  input  wire logic [3:0] raw,
  // retimed levels
  output logic      [3:0] synced
);

  typedef struct packed
  {
    logic [3:0] stage1;
    logic [3:0] stage2;
  } tpis_sync_s;

  tpis_sync_s r;
  tpis_sync_s next_r;

  // two flops per pin; only stage2 leaves this module
  always_comb
  begin
    next_r.stage1 = raw;
    next_r.stage2 = r.stage1;
  end

  // idle bus lines are high, so resetting to ones avoids a false start
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r <= {4'hf, 4'hf};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign synced = r.stage2;

endmodule // tpis_sync

// ===== verification/tpis_host_model.sv
`timescale 1ns/1ps

module tpis_host_model
(
  // clock
  input  wire logic core_clk,
  // bus wires
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  // ---------------------------------------------------------------
  // bus phases
  // ---------------------------------------------------------------
  // eight core cycles per half bit keep both scl phases over the minimum
  localparam int HALF = 8;

  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // wait on falling core edges, so every change lands off the sample edge
  task automatic gap(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // start: sda falls while scl is high
  task automatic start();
    sda_pull = 1'b0;
    gap(HALF);
    scl = 1'b1;
    gap(HALF);
    sda_pull = 1'b1;
    gap(HALF);
    scl = 1'b0;
  endtask

  // stop: sda rises while scl is high, then the line is left to pull-up
  task automatic stop();
    gap(2);
    sda_pull = 1'b1;
    gap(HALF);
    scl = 1'b1;
    gap(HALF);
    sda_pull = 1'b0;
    gap(HALF);
  endtask

  // one bit: data set a little after scl fell, sampled mid high phase
  task automatic bit_io(input logic b, output logic seen);
    gap(2);
    sda_pull = ~b;
    gap(HALF - 2);
    scl = 1'b1;
    gap(HALF / 2);
    seen = sda_line;
    gap(HALF / 2);
    scl = 1'b0;
  endtask

  // byte out msb first, ack seen as a low line in the ninth bit
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // byte in; an ack asks for another byte, a nack ends the read
  task automatic read_byte(output logic [7:0] d, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(~ack, s);
  endtask

endmodule // tpis_host_model

// ===== verification/tb.sv
`timescale 1ns/1ps

module tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic       core_clk;
  logic       resetn;
  logic       scl;
  logic       sda_pull;
  logic       sda_line;
  logic       sda_out;
  logic       sda_oe;
  logic [1:0] asel;
  logic [7:0] status;
  logic [7:0] div_hi, div_lo, ctrl, band, aux;
  logic [7:0] e_hi, e_lo, e_ctrl, e_band, e_aux;
  logic [4:0] upd;
  logic [7:0] q[$];
  int         errors;
  int         cmp_count;
  int         cycles;
  int         n_upd;

  // update pulses counted off the launching edge
  always @(negedge core_clk)
    n_upd += $countones(upd);

  // open-drain wire with pull-up: low if either party pulls
  assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));

  tpis_i2c_port DUT
  (
    .core_clk             (core_clk),
    .resetn               (resetn),
    .scl_in               (scl),
    .sda_in               (sda_line),
    .sda_out              (sda_out),
    .sda_oe               (sda_oe),
    .address_select_input (asel),
    .status_byte          (status),
    .divider_hi           (div_hi),
    .divider_lo           (div_lo),
    .control_byte         (ctrl),
    .band_byte            (band),
    .aux_byte             (aux),
    .setting_update       (upd)
  );

  tpis_host_model u_host
  (
    .core_clk (core_clk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_pull (sda_pull)
  );

  // ---------------------------------------------------------------
  // clock, timeout and closing
  // ---------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // a hung transfer is cut off well past the expected run length
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  // settings not written in a transfer must keep their old values
  task automatic check_all();
    check(div_hi, e_hi, "divider hi");
    check(div_lo, e_lo, "divider lo");
    check(ctrl, e_ctrl, "control");
    check(band, e_band, "band");
    check(aux, e_aux, "aux");
  endtask

  // one write transfer of the bytes in q; every ack compared
  task automatic wr_seq(input logic [7:0] addr, input logic exp_ack);
    logic a;
    u_host.start();
    u_host.write_byte(addr, a);
    check({7'h00, a}, {7'h00, exp_ack}, "address ack");
    foreach (q[i])
    begin
      u_host.write_byte(q[i], a);
      check({7'h00, a}, {7'h00, exp_ack}, "data ack");
    end
    u_host.stop();
    check_all();
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic sc_full_one();
    q = '{8'h06, 8'h40, 8'hce, 8'h09, 8'hde, 8'h20};
    {e_hi, e_lo, e_ctrl, e_band, e_aux} = {8'h06, 8'h40, 8'hde, 8'h09, 8'h20};
    n_upd = 0;
    wr_seq(8'hc2, 1'b1);
    check(8'(n_upd), 8'h06, "update pulses");
  endtask

  task automatic sc_full_two();
    q = '{8'hdf, 8'h21, 8'hc8, 8'h0a, 8'h07, 8'h41};
    {e_hi, e_lo, e_ctrl, e_band, e_aux} = {8'h07, 8'h41, 8'hc8, 8'h0a, 8'h21};
    wr_seq(8'hc2, 1'b1);
  endtask

  task automatic sc_short();
    q = '{8'h12, 8'h34};
    {e_hi, e_lo} = {8'h12, 8'h34};
    wr_seq(8'hc2, 1'b1);
    q = '{8'hce, 8'h09};
    {e_ctrl, e_band} = {8'hce, 8'h09};
    wr_seq(8'hc2, 1'b1);
    q = '{8'hde, 8'h20};
    {e_ctrl, e_aux} = {8'hde, 8'h20};
    wr_seq(8'hc2, 1'b1);
    q = '{8'hc6};
    e_ctrl = 8'hc6;
    wr_seq(8'hc2, 1'b1);
  endtask

  // every strap value answers its own address and ignores a neighbour
  task automatic sc_addr();
    for (int a = 0; a < 4; a++)
    begin
      @(negedge core_clk);
      asel = a[1:0];
      q = '{8'hc0 + 8'(a)};
      e_ctrl = 8'hc0 + 8'(a);
      wr_seq({tpis_pkg::ADDR_BASE, asel, 1'b0}, 1'b1);
      q = '{8'h81};
      wr_seq({tpis_pkg::ADDR_BASE, asel ^ 2'h1, 1'b0}, 1'b0);
    end
  endtask

  // one byte then nack, then two bytes with an ack between
  task automatic sc_read();
    logic       a;
    logic [7:0] d;
    @(negedge core_clk);
    asel = 2'h1;
    status = 8'ha5;
    u_host.start();
    u_host.write_byte(8'hc3, a);
    check({7'h00, a}, 8'h01, "read address ack");
    u_host.read_byte(d, 1'b0);
    check(d, 8'ha5, "status byte");
    u_host.stop();
    check({7'h00, sda_oe}, 8'h00, "line released");
    status = 8'h3c;
    u_host.start();
    u_host.write_byte(8'hc3, a);
    u_host.read_byte(d, 1'b1);
    check(d, 8'h3c, "first of two");
    u_host.read_byte(d, 1'b0);
    check(d, 8'h3c, "second of two");
    check({7'h00, sda_out}, 8'h00, "open drain level");
    u_host.stop();
    check({7'h00, sda_oe}, 8'h00, "line released");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    asel = 2'h1;
    status = 8'h00;
    errors = 0;
    cmp_count = 0;
    cycles = 0;
    n_upd = 0;
    {e_hi, e_lo, e_ctrl, e_band, e_aux} = {5{tpis_pkg::SETTING_RESET}};
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    check_all();
    sc_full_one();
    sc_full_two();
    sc_short();
    sc_addr();
    sc_read();
    summarize();
  end

endmodule // tb
